// ---- verilog/arr_pkg.sv ----
package arr_pkg;
  // converter data layout
  localparam int RES_W = 10;
  localparam int PAD_W = 6;
  localparam int NUM_RES = 4;
  localparam logic [15:0] RES_RESET = 16'h0000;
  localparam logic [PAD_W-1:0] PAD_ZERO = 6'h00;

  // byte addresses on the 8-bit cpu path
  localparam logic [3:0] ADDR_RES_A_HI = 4'h0;
  localparam logic [3:0] ADDR_RES_A_LO = 4'h1;
  localparam logic [3:0] ADDR_RES_B_HI = 4'h2;
  localparam logic [3:0] ADDR_RES_B_LO = 4'h3;
  localparam logic [3:0] ADDR_RES_C_HI = 4'h4;
  localparam logic [3:0] ADDR_RES_C_LO = 4'h5;
  localparam logic [3:0] ADDR_RES_D_HI = 4'h6;
  localparam logic [3:0] ADDR_RES_D_LO = 4'h7;
  localparam logic [3:0] ADDR_CSR = 4'h8;

  // control/status byte fields
  localparam int BIT_END = 7;
  localparam int BIT_IRQEN = 6;
  localparam int BIT_START = 5;
  localparam int BIT_SCAN = 4;
  localparam int BIT_CKS = 3;
  localparam int BIT_GROUP = 2;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // conversion time, one state is one system clock
  localparam int CLK_NS = 20;
  localparam int STATE_NS = 20;
  localparam int CONV_STATES_SLOW = 134;
  localparam int CONV_STATES_FAST = 70;
  localparam logic [7:0] CONV_CYC_SLOW =
    8'((CONV_STATES_SLOW * STATE_NS) / CLK_NS);
  localparam logic [7:0] CONV_CYC_FAST =
    8'((CONV_STATES_FAST * STATE_NS) / CLK_NS);

  // sequencer states
  typedef enum logic [2:0] {
    ARR_IDLE = 3'h1,
    ARR_CONV = 3'h2,
    ARR_HOLD = 3'h4
  } arr_state_t;
endpackage

// ---- verilog/arr_conv_if.sv ----
`timescale 1ns/1ps
interface arr_conv_if;
  // control from the register side
  logic run;
  logic scan;
  logic conv_time_select;
  logic [2:0] chSel;
  // results from the sequencer
  logic done;
  logic passEnd;
  logic [1:0] idx;
  logic [arr_pkg::RES_W-1:0] data;
  logic [2:0] chan;
  logic sampling;

  modport ctl (output run, scan, conv_time_select, chSel,
               input done, passEnd, idx, data, chan, sampling);
  modport seq (input run, scan, conv_time_select, chSel,
               output done, passEnd, idx, data, chan, sampling);
endinterface

// ---- verilog/arr_conv_seq.sv ----
`timescale 1ns/1ps
module arr_conv_seq (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // converter core result
  input wire logic [arr_pkg::RES_W-1:0] anaResult,
  // register side
  arr_conv_if.seq cv
);
  arr_pkg::arr_state_t stateReg, stateNext;
  logic [7:0] cntReg, cntNext;
  logic [7:0] limit;
  logic [2:0] chanReg, chanNext;
  logic doneReg, doneNext, passReg, passNext;
  logic [1:0] idxReg, idxNext;
  logic [arr_pkg::RES_W-1:0] dataReg, dataNext;

  assign limit = cv.conv_time_select ? arr_pkg::CONV_CYC_FAST : arr_pkg::CONV_CYC_SLOW;

  // step channels; scan walks 0..the selected channel of the group, then wraps
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    chanNext = chanReg;
    doneNext = 1'b0;
    passNext = 1'b0;
    idxNext = idxReg;
    dataNext = dataReg;
    case (stateReg)
      arr_pkg::ARR_IDLE: begin
        cntNext = 8'h00;
        if (cv.run) begin
          stateNext = arr_pkg::ARR_CONV;
          chanNext = cv.scan ? {cv.chSel[2], 2'h0} : cv.chSel;
        end
      end
      arr_pkg::ARR_CONV: begin
        cntNext = cntReg + 8'h01;
        if (!cv.run) begin
          // an abort on the last count would leave the limit in idle
          cntNext = 8'h00;
          stateNext = arr_pkg::ARR_IDLE; // aborted by software
        end else if (cntReg == limit - 8'h01) begin
          cntNext = 8'h00;
          doneNext = 1'b1;
          idxNext = chanReg[1:0];
          dataNext = anaResult;
          if (!cv.scan) begin
            passNext = 1'b1;
            stateNext = arr_pkg::ARR_HOLD;
          end else if (chanReg[1:0] == cv.chSel[1:0]) begin
            passNext = 1'b1;
            chanNext = {cv.chSel[2], 2'h0};
          end else begin
            chanNext = chanReg + 3'h1;
          end
        end
      end
      arr_pkg::ARR_HOLD: begin
        // wait for start bit to drop so one start gives one result
        if (!cv.run) begin
          stateNext = arr_pkg::ARR_IDLE;
        end
      end
      default: stateNext = arr_pkg::ARR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stateReg <= arr_pkg::ARR_IDLE;
      cntReg <= 8'h00;
      chanReg <= 3'h0;
      doneReg <= 1'b0;
      passReg <= 1'b0;
      idxReg <= 2'h0;
      dataReg <= '0;
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      chanReg <= chanNext;
      doneReg <= doneNext;
      passReg <= passNext;
      idxReg <= idxNext;
      dataReg <= dataNext;
    end
  end

  assign cv.done = doneReg;
  assign cv.passEnd = passReg;
  assign cv.idx = idxReg;
  assign cv.data = dataReg;
  assign cv.chan = chanReg;
  assign cv.sampling = (stateReg == arr_pkg::ARR_CONV);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  conv_time_a: assert property (
    cntReg < limit) else $error("conversion count past limit");
  scan_group_a: assert property (
    cv.sampling && cv.scan |-> chanReg[2] == cv.chSel[2])
    else $error("scan left its group");
endmodule

// ---- verilog/arr_readout.sv ----
`timescale 1ns/1ps
// Behaviour
// - four read-only 16-bit result registers
// - 10-bit result stored in bits 15 down to 6
// - low six bits of each result always read zero
// - high byte read directly, low byte read from holding latch
// - reading high byte copies low byte into holding latch
// - result registers reset to zero
// - inputs 0-3 form group 0, inputs 4-7 group 1
// - position within group selects result register a to d
// - single mode converts one channel, scan repeats 1 to 4
// - start by software bit or external trigger pin
// - conversion-complete interrupt request toward processor
// - start bit self-clears in single mode, holds in scan
// - end flag set per conversion or pass; cleared by read-1-write-0
// - interrupt asserted only when end flag and enable both set
// - time select picks 134 or 70 states maximum
module arr_readout (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // 8-bit cpu data path
  input wire logic [3:0] busAddr,
  input wire logic busRd,
  input wire logic busWr,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  // trigger pin and interrupt
  input wire logic extConvertTrigger,
  output logic conversionDoneIrq,
  // converter core
  input wire logic [arr_pkg::RES_W-1:0] anaResult,
  output logic [2:0] anaChan,
  output logic anaSample
);
  arr_conv_if cv ();

  logic [15:0] resReg [arr_pkg::NUM_RES];
  logic [15:0] resNext [arr_pkg::NUM_RES];
  logic [7:0] tempReg, tempNext, rdReg, rdNext;
  logic endReg, endNext, armReg, armNext;
  logic ieReg, ieNext, startReg, startNext;
  logic scanReg, scanNext, cksReg, cksNext;
  logic [2:0] chReg, chNext;
  logic irqReg, irqNext;
  logic trgS1, trgS2, trgS3, trgLvlReg, trgLvlNext, trgRise;
  logic [2:0] chanReg, chanNext;
  logic sampleReg, sampleNext;
  logic isRes, isHi, isCsr;
  logic [1:0] selIdx;
  logic [7:0] csrView;

  arr_conv_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .anaResult(anaResult),
    .cv(cv.seq)
  );

  assign cv.run = startReg;
  assign cv.scan = scanReg;
  assign cv.conv_time_select = cksReg;
  assign cv.chSel = chReg;

  // address decode; result bytes sit below the csr
  assign isRes = (busAddr <= arr_pkg::ADDR_RES_D_LO);
  assign isHi = isRes && !busAddr[0];
  assign isCsr = (busAddr == arr_pkg::ADDR_CSR);
  assign selIdx = busAddr[2:1];
  assign csrView = {endReg, ieReg, startReg, scanReg, cksReg, chReg};

  // pin filter: level moves only when second and third stages agree
  always_comb begin
    trgLvlNext = trgLvlReg;
    if (trgS2 == trgS3) begin
      trgLvlNext = trgS3;
    end
  end
  assign trgRise = trgLvlNext && !trgLvlReg;

  // register file and cpu read path
  always_comb begin
    for (int i = 0; i < arr_pkg::NUM_RES; i++) begin
      resNext[i] = resReg[i];
    end
    tempNext = tempReg;
    rdNext = rdReg;
    endNext = endReg;
    armNext = armReg;
    ieNext = ieReg;
    startNext = startReg;
    scanNext = scanReg;
    cksNext = cksReg;
    chNext = chReg;
    // left-justified store, low bits padded zero
    if (cv.done) begin
      resNext[cv.idx] = {cv.data, arr_pkg::PAD_ZERO};
    end
    if (busRd) begin
      if (isHi) begin
        rdNext = resReg[selIdx][15:8];
        // low byte latched with the high-byte read
        tempNext = resReg[selIdx][7:0];
      end else if (isRes) begin
        rdNext = tempReg;
      end else if (isCsr) begin
        rdNext = csrView;
        if (endReg) begin
          armNext = 1'b1; // flag seen as one
        end
      end else begin
        rdNext = 8'h00; // unmapped reads zero
      end
    end
    if (busWr && isCsr) begin
      ieNext = busWdata[arr_pkg::BIT_IRQEN];
      startNext = busWdata[arr_pkg::BIT_START];
      scanNext = busWdata[arr_pkg::BIT_SCAN];
      cksNext = busWdata[arr_pkg::BIT_CKS];
      chNext = busWdata[2:0];
      if (armReg && !busWdata[arr_pkg::BIT_END]) begin
        endNext = 1'b0;
      end
      armNext = 1'b0;
    end
    // single mode drops start at completion
    if (cv.passEnd && !scanReg && !(busWr && isCsr)) begin
      startNext = 1'b0;
    end
    if (trgRise) begin
      startNext = 1'b1;
    end
    // set wins over a clear in the same cycle
    if (cv.passEnd) begin
      endNext = 1'b1;
    end
  end

  // request gated by flag and enable
  assign irqNext = endReg && ieReg;
  assign chanNext = cv.chan;
  assign sampleNext = cv.sampling;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < arr_pkg::NUM_RES; i++) begin
        resReg[i] <= arr_pkg::RES_RESET;
      end
      tempReg <= 8'h00;
      rdReg <= 8'h00;
      endReg <= arr_pkg::CSR_RESET[arr_pkg::BIT_END];
      armReg <= 1'b0;
      ieReg <= arr_pkg::CSR_RESET[arr_pkg::BIT_IRQEN];
      startReg <= arr_pkg::CSR_RESET[arr_pkg::BIT_START];
      scanReg <= arr_pkg::CSR_RESET[arr_pkg::BIT_SCAN];
      cksReg <= arr_pkg::CSR_RESET[arr_pkg::BIT_CKS];
      chReg <= arr_pkg::CSR_RESET[2:0];
      irqReg <= 1'b0;
      trgS1 <= 1'b0;
      trgS2 <= 1'b0;
      trgS3 <= 1'b0;
      trgLvlReg <= 1'b0;
      chanReg <= 3'h0;
      sampleReg <= 1'b0;
    end else begin
      for (int i = 0; i < arr_pkg::NUM_RES; i++) begin
        resReg[i] <= resNext[i];
      end
      tempReg <= tempNext;
      rdReg <= rdNext;
      endReg <= endNext;
      armReg <= armNext;
      ieReg <= ieNext;
      startReg <= startNext;
      scanReg <= scanNext;
      cksReg <= cksNext;
      chReg <= chNext;
      irqReg <= irqNext;
      trgS1 <= extConvertTrigger;
      trgS2 <= trgS1;
      trgS3 <= trgS2;
      trgLvlReg <= trgLvlNext;
      chanReg <= chanNext;
      sampleReg <= sampleNext;
    end
  end

  assign conversionDoneIrq = irqReg;
  assign busRdata = rdReg;
  assign anaChan = chanReg;
  assign anaSample = sampleReg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  low_bits_zero_a: assert property (
    (resReg[0][5:0] | resReg[1][5:0] | resReg[2][5:0] |
     resReg[3][5:0]) == 6'h00) else $error("result low bits not zero");
  result_store_a: assert property (
    cv.done |=> resReg[$past(cv.idx)] ==
      {$past(cv.data), arr_pkg::PAD_ZERO})
    else $error("result not stored in mapped register");
  high_read_a: assert property (
    busRd && isHi |=> busRdata == $past(resReg[selIdx][15:8]))
    else $error("high byte read wrong");
  low_read_a: assert property (
    busRd && isRes && !isHi |=> busRdata == $past(tempReg))
    else $error("low byte not from latch");
  temp_copy_a: assert property (
    busRd && isHi && !cv.done |=> tempReg == resReg[$past(selIdx)][7:0])
    else $error("holding latch not loaded");
  irq_gate_a: assert property (
    conversionDoneIrq |-> $past(endReg) && $past(ieReg))
    else $error("interrupt without flag and enable");
  end_flag_a: assert property (
    cv.passEnd |=> endReg) else $error("end flag not set");
  single_clear_a: assert property (
    cv.passEnd && !scanReg && !busWr && !trgRise |=> !startReg)
    else $error("start bit not cleared in single mode");
  trig_start_a: assert property (
    trgRise |=> startReg) else $error("trigger did not start");

  single_cov: cover property (cv.passEnd && !scanReg);
  scan_cov: cover property (cv.passEnd && scanReg ##1 cv.done);
  trig_cov: cover property (trgRise ##[1:200] cv.done);
  irq_cov: cover property (conversionDoneIrq);
endmodule

// ---- verification/arr_core_model.sv ----
`timescale 1ns/1ps
// converter core stand-in: each channel gives its own code
module arr_core_model (
  // bench knob, lands in the low byte so latch tests can tell codes apart
  input wire logic [1:0] salt,
  // design side
  input wire logic [2:0] anaChan,
  input wire logic anaSample,
  output logic [arr_pkg::RES_W-1:0] anaResult
);
  logic [arr_pkg::RES_W-1:0] codeVal;
  // outside sampling show the inverse, so a late sample is caught
  assign codeVal = {anaChan, 5'h15, salt};
  assign anaResult = anaSample ? codeVal : ~codeVal;
endmodule

// ---- verification/arr_readout_bench.sv ----
`timescale 1ns/1ps
module arr_readout_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] busAddr = 4'h0;
  logic busRd = 1'b0;
  logic busWr = 1'b0;
  logic [7:0] busWdata = 8'h00;
  logic [7:0] busRdata;
  logic extConvertTrigger = 1'b0;
  logic conversionDoneIrq;
  logic [9:0] anaResult;
  logic [2:0] anaChan;
  logic anaSample;
  logic [1:0] salt = 2'h0;
  logic [7:0] rd;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  arr_readout dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .busAddr(busAddr), .busRd(busRd),
    .busWr(busWr), .busWdata(busWdata), .busRdata(busRdata),
    .extConvertTrigger(extConvertTrigger),
    .conversionDoneIrq(conversionDoneIrq), .anaResult(anaResult),
    .anaChan(anaChan), .anaSample(anaSample)
  );

  arr_core_model core_u (
    .salt(salt), .anaChan(anaChan), .anaSample(anaSample),
    .anaResult(anaResult)
  );

  // verdict and stop
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // compare and report
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one byte write, strobe held for one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask

  // one byte read; data taken a cycle later, it holds till next read
  task automatic rdb(input logic [3:0] a);
    @(posedge ref_clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRd <= 1'b0;
    @(posedge ref_clk);
    #1 rd = busRdata;
  endtask

  task automatic rdres(input int k, output logic [15:0] v);
    rdb(4'(2 * k));
    v[15:8] = rd;
    rdb(4'(2 * k + 1));
    v[7:0] = rd;
  endtask

  // bounded wait for the interrupt; n counts edges since the write
  task automatic wait_irq();
    n = 0;
    while (conversionDoneIrq !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("irq raised", {15'h0, conversionDoneIrq}, 16'h1);
  endtask

  // read status (flag seen as one), then write the keep byte, whose flag bit is zero
  task automatic clear_end(input logic [7:0] exp, input logic [7:0] keep);
    rdb(arr_pkg::ADDR_CSR);
    check("csr", {8'h00, rd}, {8'h00, exp});
    wr(arr_pkg::ADDR_CSR, keep);
  endtask

  function automatic logic [15:0] expv(input logic [2:0] ch,
                                       input logic [1:0] s);
    return {ch, 5'h15, s, 6'h00};
  endfunction

  // hang guard, about a thousand cycles expected
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    logic [15:0] v;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // results clear after reset and ignore writes
    for (int k = 0; k < 4; k++) begin
      wr(4'(2 * k), 8'hff);
      rdres(k, v);
      check("result reset", v, arr_pkg::RES_RESET);
    end
    rdb(4'h9);
    check("unmapped", {8'h00, rd}, 16'h0000);
    // single mode, short time, channel 1 into register b
    salt <= 2'h1;
    wr(arr_pkg::ADDR_CSR, 8'h69);
    wait_irq();
    check("fast time", {15'h0, n >= 70 && n <= 78}, 16'h1);
    rdres(1, v);
    check("result b", v, expv(3'h1, 2'h1));
    clear_end(8'hc9, 8'h40);
    repeat (2) @(posedge ref_clk);
    #1 check("irq cleared", {15'h0, conversionDoneIrq}, 16'h0);
    // long time, channel 6 of group 1 into register c
    salt <= 2'h2;
    wr(arr_pkg::ADDR_CSR, 8'h66);
    wait_irq();
    check("slow time", {15'h0, n >= 134 && n <= 142}, 16'h1);
    rdres(2, v);
    check("result c", v, expv(3'h6, 2'h2));
    clear_end(8'hc6, 8'h00);
    // latch keeps old low byte while c is overwritten
    rdb(arr_pkg::ADDR_RES_C_HI);
    v[15:8] = rd;
    salt <= 2'h3;
    wr(arr_pkg::ADDR_CSR, 8'h6a);
    wait_irq();
    rdb(arr_pkg::ADDR_RES_C_LO);
    check("coherent c", {v[15:8], rd}, expv(3'h6, 2'h2));
    rdres(2, v);
    check("new c", v, expv(3'h2, 2'h3));
    clear_end(8'hca, 8'h00);
    // scan group 1, four channels; start stays set after a pass
    salt <= 2'h1;
    wr(arr_pkg::ADDR_CSR, 8'h7f);
    wait_irq();
    clear_end(8'hff, 8'h40);
    for (int k = 0; k < 4; k++) begin
      rdres(k, v);
      check("scan result", v, expv(3'(4 + k), 2'h1));
    end
    // scan group 0, two channels; d keeps its group 1 code
    salt <= 2'h3;
    wr(arr_pkg::ADDR_CSR, 8'h79);
    wait_irq();
    clear_end(8'hf9, 8'h40);
    rdres(0, v);
    check("scan a", v, expv(3'h0, 2'h3));
    rdres(1, v);
    check("scan b", v, expv(3'h1, 2'h3));
    rdres(3, v);
    check("scan d kept", v, expv(3'h7, 2'h1));
    // pin start, interrupt disabled, channel 3 into register d
    salt <= 2'h2;
    wr(arr_pkg::ADDR_CSR, 8'h0b);
    @(posedge ref_clk);
    extConvertTrigger <= 1'b1;
    repeat (6) @(posedge ref_clk);
    extConvertTrigger <= 1'b0;
    rd = 8'h00;
    for (int i = 0; i < 60 && rd[7] !== 1'b1; i++) begin
      rdb(arr_pkg::ADDR_CSR);
    end
    check("irq masked", {15'h0, conversionDoneIrq}, 16'h0);
    rdres(3, v);
    check("result d", v, expv(3'h3, 2'h2));
    clear_end(8'h8b, 8'h00);
    end_of_test();
  end
endmodule
